// ---- logic/drsc_consts.svh ----
`ifndef DRSC_CONSTS_SVH
`define DRSC_CONSTS_SVH

// Register byte addresses and address width
`define DRSC_ADDR_W 12
`define DRSC_OFF_READ_SPACING 12'h658
`define DRSC_OFF_CKE_CTRL 12'h660

// Reset values (read spacing is 20 bits wide, upper bits read zero)
`define DRSC_RST_READ_SPACING 32'h00000000
`define DRSC_RST_CKE_CTRL 32'h00000800

// Writable bits; reserved bits 31:20 of read spacing stay zero
`define DRSC_WMASK_READ_SPACING 32'h000fffff
`define DRSC_WMASK_CKE_CTRL 32'hffffffff

// Read spacing fields
`define DRSC_F_ACT_RD 19:16
`define DRSC_F_WRSR_RD 15:11
`define DRSC_F_WRDR_RD 10:8
`define DRSC_F_RDSR_RD 7:4
`define DRSC_F_RDDR_RD 3:0

// Clock-enable control fields
`define DRSC_F_RD_TERM_DLY 31:30
`define DRSC_F_WR_TERM_DLY 29:28
`define DRSC_B_SRX_REQ 27
`define DRSC_F_HIGH_W 26:24
`define DRSC_F_PRESENT 23:20
`define DRSC_F_LOW_W 19:17
`define DRSC_B_PDN_EN 16
`define DRSC_B_RD_UNSAFE 15
`define DRSC_B_WR_UNSAFE 14
`define DRSC_F_PD_EXIT_GAP 13:10
`define DRSC_F_SRX_WAIT 9:1
`define DRSC_B_SINGLE 0

// Legal range of the power-down exit gap code, in clocks
`define DRSC_PD_EXIT_MIN 4'h2
`define DRSC_PD_EXIT_MAX 4'h9

`endif

// ---- logic/drsc_pkg.sv ----
package drsc_pkg;
  // Command kinds on the request and issue ports
  typedef enum logic [1:0] {
    DRSC_ACT,
    DRSC_READ,
    DRSC_WRITE,
    DRSC_OTHER
  } drsc_kind_t;

  // Clock-enable sequencer states
  typedef enum logic [1:0] {
    DRSC_CKE_HELD,
    DRSC_CKE_UP,
    DRSC_CKE_DOWN
  } drsc_cke_st_t;
endpackage

// ---- logic/drsc_cke_if.sv ----
`timescale 1ns/1ps
interface drsc_cke_if;
  // Settings from the control register
  logic pdn_en;
  logic [2:0] high_w;
  logic [2:0] low_w;
  logic [3:0] pd_exit_gap;
  logic srx_req;
  logic [8:0] srx_wait;
  logic [3:0] present;
  // Scheduler status
  logic pd_req;
  logic busy;
  // Results back to the scheduler
  logic [3:0] cke;
  logic read_ok;
  logic nonread_ok;
  logic srx_done;

  modport ctrl (
    output pdn_en, high_w, low_w, pd_exit_gap, srx_req, srx_wait,
    output present, pd_req, busy,
    input cke, read_ok, nonread_ok, srx_done
  );
  modport seq (
    input pdn_en, high_w, low_w, pd_exit_gap, srx_req, srx_wait,
    input present, pd_req, busy,
    output cke, read_ok, nonread_ok, srx_done
  );
endinterface // drsc_cke_if

// ---- logic/drsc_gap_counter.sv ----
`timescale 1ns/1ps
module drsc_gap_counter #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Restart when the tracked command is issued
  input wire logic i_restart,
  // Clocks since the last restart, saturating
  output logic [W-1:0] o_count
);
  typedef struct packed {
    logic [W-1:0] count;
  } drsc_gap_st_t;

  drsc_gap_st_t state;
  drsc_gap_st_t next_state;

  // Saturation keeps an old command looking "long ago" forever
  always_comb begin
    next_state = state;
    if (i_restart) begin
      next_state.count = '0;
    end else if (state.count != '1) begin
      next_state.count = W'(state.count + 1'b1);
    end
  end

  // Reset to saturated: no earlier command constrains anything
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state.count <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign o_count = state.count;
endmodule // drsc_gap_counter

// ---- logic/drsc_cke_seq.sv ----
`timescale 1ns/1ps
`include "drsc_consts.svh"
module drsc_cke_seq (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Link to the scheduler
  drsc_cke_if.seq i_cke_if
);
  typedef struct packed {
    drsc_pkg::drsc_cke_st_t st;
    logic [3:0] lvl_cnt;
    logic [3:0] exit_cnt;
    logic [8:0] srx_cnt;
    logic srx_active;
    logic srx_done;
    logic [3:0] cke;
  } drsc_cke_state_t;

  drsc_cke_state_t state;
  drsc_cke_state_t next_state;
  logic [3:0] gap_eff;

  // Reserved gap codes are clamped into the legal 2..9 range
  always_comb begin
    gap_eff = i_cke_if.pd_exit_gap;
    if (gap_eff < `DRSC_PD_EXIT_MIN) gap_eff = `DRSC_PD_EXIT_MIN;
    if (gap_eff > `DRSC_PD_EXIT_MAX) gap_eff = `DRSC_PD_EXIT_MAX;
  end

  // Level width, exit gap and self-refresh exit sequencing
  always_comb begin
    next_state = state;
    next_state.srx_done = 1'b0;
    if (state.lvl_cnt != 4'hf) next_state.lvl_cnt = state.lvl_cnt + 4'h1;
    if (state.exit_cnt != 4'hf) next_state.exit_cnt = state.exit_cnt + 4'h1;
    if (state.srx_active) begin
      if (state.srx_cnt >= i_cke_if.srx_wait) begin
        next_state.srx_active = 1'b0;
        next_state.srx_done = 1'b1;
      end else begin
        next_state.srx_cnt = state.srx_cnt + 9'h001;
      end
    end
    case (state.st)
      drsc_pkg::DRSC_CKE_HELD: begin
        if (i_cke_if.srx_req &&
            state.lvl_cnt >= {1'b0, i_cke_if.low_w}) begin
          next_state.st = drsc_pkg::DRSC_CKE_UP;
          next_state.lvl_cnt = 4'h1;
          next_state.exit_cnt = 4'h0;
          next_state.srx_active = 1'b1;
          next_state.srx_cnt = 9'h000;
        end
      end
      drsc_pkg::DRSC_CKE_UP: begin
        if (i_cke_if.srx_req && !state.srx_active) begin
          next_state.srx_done = 1'b1; // Nothing to leave, just retire it
        end else if (i_cke_if.pdn_en && i_cke_if.pd_req &&
                     !i_cke_if.busy && !state.srx_active &&
                     state.lvl_cnt >= {1'b0, i_cke_if.high_w}) begin
          next_state.st = drsc_pkg::DRSC_CKE_DOWN;
          next_state.lvl_cnt = 4'h1;
        end
      end
      drsc_pkg::DRSC_CKE_DOWN: begin
        if (i_cke_if.pdn_en && !i_cke_if.pd_req &&
            state.lvl_cnt >= {1'b0, i_cke_if.low_w}) begin
          next_state.st = drsc_pkg::DRSC_CKE_UP;
          next_state.lvl_cnt = 4'h1;
          next_state.exit_cnt = 4'h0;
        end
      end
      default: begin
        next_state.st = drsc_pkg::DRSC_CKE_HELD;
      end
    endcase
    // Absent ranks never see clock enable
    next_state.cke = (next_state.st == drsc_pkg::DRSC_CKE_UP) ?
                     i_cke_if.present : 4'h0;
  end

  // Held low from reset until software asks for the exit sequence
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= '{st: drsc_pkg::DRSC_CKE_HELD, lvl_cnt: 4'h0,
                 exit_cnt: 4'h0, srx_cnt: 9'h000, srx_active: 1'b0,
                 srx_done: 1'b0, cke: 4'h0};
    end else begin
      state <= next_state;
    end
  end

  // Ok flags say whether a command may go out on the next edge
  assign i_cke_if.cke = state.cke;
  assign i_cke_if.srx_done = state.srx_done;
  assign i_cke_if.read_ok = (state.st == drsc_pkg::DRSC_CKE_UP) &&
                            !state.srx_active;
  assign i_cke_if.nonread_ok = i_cke_if.read_ok &&
    (({1'b0, state.exit_cnt} + 5'h01) >= {1'b0, gap_eff});

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence pd_exit_s;
    $fell(state.st == drsc_pkg::DRSC_CKE_DOWN);
  endsequence
  sequence srx_go_s;
    state.st == drsc_pkg::DRSC_CKE_HELD && i_cke_if.srx_req &&
      state.lvl_cnt >= {1'b0, i_cke_if.low_w};
  endsequence

  high_width_a: assert property (
    $rose(state.st == drsc_pkg::DRSC_CKE_DOWN) |->
      $past(state.lvl_cnt) >= {1'b0, $past(i_cke_if.high_w)})
    else $error("clock enable high phase too short");
  low_width_a: assert property (
    $rose(state.st == drsc_pkg::DRSC_CKE_UP) |->
      $past(state.lvl_cnt) >= {1'b0, $past(i_cke_if.low_w)})
    else $error("clock enable low phase too short");
  pdn_toggle_a: assert property (
    ($rose(state.st == drsc_pkg::DRSC_CKE_DOWN) ||
     $fell(state.st == drsc_pkg::DRSC_CKE_DOWN))
      |-> $past(i_cke_if.pdn_en))
    else $error("power-down toggle while disabled");
  exit_gap_a: assert property (
    pd_exit_s |-> !i_cke_if.nonread_ok)
    else $error("non-read allowed right after power-down exit");
  srx_start_a: assert property (
    srx_go_s |=> (i_cke_if.cke == $past(i_cke_if.present)) &&
      state.srx_active && !i_cke_if.read_ok)
    else $error("self-refresh exit did not start");
endmodule // drsc_cke_seq

// ---- logic/drsc_read_spacing.sv ----
`timescale 1ns/1ps
`include "drsc_consts.svh"

// What this block does
// - A read waits the activate-to-read gap after activating its rank-bank.
// - A read waits the write-to-read gap after a write to its rank.
// - A read waits the other-rank write gap after writes to other ranks.
// - Reads to one rank are spaced by the same-rank read gap.
// - Reads to different ranks are spaced by the other-rank read gap.
// - Read termination safe rises the programmed clocks after start if unsafe.
// - Write termination safe rises the programmed clocks after start if unsafe.
// - Setting the exit request starts the self-refresh exit sequence.
// - Clock enable stays high at least the high-phase width.
// - Clock enable stays low at least the low-phase width.
// - Commands only go to ranks marked present.
// - Power-down entry and exit toggle only while enabled.
// - After power-down exit, non-read commands wait the exit gap, 2 to 9.
// - After self-refresh exit, all commands wait the programmed exit count.
// - Single-module flag limits commands to ranks 0 and 1.
module drsc_read_spacing #(
  parameter int NUM_RANKS = 4,
  parameter int NUM_BANKS = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Register access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [`DRSC_ADDR_W-1:0] i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Command request from the scheduler
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd_kind,
  input wire logic [1:0] i_cmd_rank,
  input wire logic [2:0] i_cmd_bank,
  output logic o_cmd_ready,
  // Command issue toward the ranks
  output logic o_issue_valid,
  output logic [1:0] o_issue_kind,
  output logic [1:0] o_issue_rank,
  output logic [2:0] o_issue_bank,
  output logic o_cmd_drop,
  // Power-down and clock enable
  input wire logic i_pd_req,
  output logic [3:0] o_cke,
  // Termination safe indications
  input wire logic i_rd_term_start,
  input wire logic i_wr_term_start,
  output logic o_rd_term_safe,
  output logic o_wr_term_safe
);
  localparam int NUM_RB = NUM_RANKS * NUM_BANKS;

  typedef struct packed {
    logic [31:0] spacing;
    logic [31:0] cke_ctrl;
    logic [31:0] rdata;
    logic rvalid;
    logic ready;
    logic pend;
    logic [1:0] kind;
    logic [1:0] rank;
    logic [2:0] bank;
    logic issue;
    logic drop;
    logic [1:0][1:0] term_cnt;
    logic [1:0] term_safe;
  } drsc_state_t;

  drsc_state_t state;
  drsc_state_t next_state;

  // Elapsed-clock trackers, a write and a read one per rank and one per rank-bank
  logic [4:0] wr_cnt [NUM_RANKS];
  logic [4:0] rd_cnt [NUM_RANKS];
  logic [4:0] act_cnt [NUM_RB];
  logic [NUM_RANKS-1:0] wr_restart;
  logic [NUM_RANKS-1:0] rd_restart;
  logic [NUM_RB-1:0] act_restart;

  drsc_cke_if cke_link ();

  drsc_cke_seq u_cke_seq (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_cke_if(cke_link.seq)
  );

  // Control register fields toward the clock-enable sequencer
  assign cke_link.pdn_en = state.cke_ctrl[`DRSC_B_PDN_EN];
  assign cke_link.high_w = state.cke_ctrl[`DRSC_F_HIGH_W];
  assign cke_link.low_w = state.cke_ctrl[`DRSC_F_LOW_W];
  assign cke_link.pd_exit_gap = state.cke_ctrl[`DRSC_F_PD_EXIT_GAP];
  assign cke_link.srx_req = state.cke_ctrl[`DRSC_B_SRX_REQ];
  assign cke_link.srx_wait = state.cke_ctrl[`DRSC_F_SRX_WAIT];
  assign cke_link.present = state.cke_ctrl[`DRSC_F_PRESENT];
  assign cke_link.pd_req = i_pd_req;
  // A held command keeps the ranks awake so it cannot be stranded
  assign cke_link.busy = state.pend;

  // Trackers restart on the same edge that the command goes out
  genvar g;
  generate
    for (g = 0; g < NUM_RB; g++) begin : g_rb
      if (g < NUM_RANKS) begin : g_rank
        assign wr_restart[g] = next_state.issue &&
          next_state.kind == drsc_pkg::DRSC_WRITE &&
          next_state.rank == 2'(g);
        assign rd_restart[g] = next_state.issue &&
          next_state.kind == drsc_pkg::DRSC_READ &&
          next_state.rank == 2'(g);
        drsc_gap_counter #(.W(5)) u_wr (
          .i_sys_clk(i_sys_clk),
          .i_rstn(i_rstn),
          .i_restart(wr_restart[g]),
          .o_count(wr_cnt[g])
        );
        drsc_gap_counter #(.W(5)) u_rd (
          .i_sys_clk(i_sys_clk),
          .i_rstn(i_rstn),
          .i_restart(rd_restart[g]),
          .o_count(rd_cnt[g])
        );
      end
      assign act_restart[g] = next_state.issue &&
        next_state.kind == drsc_pkg::DRSC_ACT &&
        {next_state.rank, next_state.bank} == 5'(g);
      drsc_gap_counter #(.W(5)) u_act (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_restart(act_restart[g]),
        .o_count(act_cnt[g])
      );
    end
  endgenerate

  // Count in cycle c is compared as c+1, the cycle of the issue
  function automatic logic gap_met(input logic [4:0] cnt,
                                   input logic [4:0] gap);
    gap_met = ({1'b0, cnt} + 6'h01) >= {1'b0, gap};
  endfunction

  // Register access, command holding and termination delays
  always_comb begin
    logic rd_ok;
    logic pop_ok;
    logic srx_set;
    logic [1:0] dly;
    rd_ok = 1'b0;
    pop_ok = 1'b0;
    srx_set = 1'b0;
    dly = 2'h0;
    next_state = state;
    next_state.issue = 1'b0;
    next_state.drop = 1'b0;
    next_state.rvalid = i_reg_rd;

    // Byte-lane writes; masks keep reserved bits at zero
    for (int b = 0; b < 4; b++) begin
      if (i_reg_wr && i_reg_be[b]) begin
        if (i_reg_addr == `DRSC_OFF_READ_SPACING) begin
          next_state.spacing[b*8 +: 8] = i_reg_wdata[b*8 +: 8] &
            8'(`DRSC_WMASK_READ_SPACING >> (b*8));
        end
        if (i_reg_addr == `DRSC_OFF_CKE_CTRL) begin
          next_state.cke_ctrl[b*8 +: 8] = i_reg_wdata[b*8 +: 8] &
            8'(`DRSC_WMASK_CKE_CTRL >> (b*8));
        end
      end
    end
    // A fresh request written with the retire pulse survives it
    srx_set = i_reg_wr && i_reg_be[3] &&
              i_reg_addr == `DRSC_OFF_CKE_CTRL &&
              i_reg_wdata[`DRSC_B_SRX_REQ];
    if (cke_link.srx_done && !srx_set) begin
      next_state.cke_ctrl[`DRSC_B_SRX_REQ] = 1'b0;
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `DRSC_OFF_READ_SPACING) begin
        next_state.rdata = state.spacing;
      end else if (i_reg_addr == `DRSC_OFF_CKE_CTRL) begin
        next_state.rdata = state.cke_ctrl;
      end else begin
        next_state.rdata = 32'h00000000;
      end
    end

    // Gaps for a read to the held rank and bank
    rd_ok = gap_met(act_cnt[{state.rank, state.bank}],
                    {1'b0, state.spacing[`DRSC_F_ACT_RD]}) &&
            gap_met(wr_cnt[state.rank],
                    state.spacing[`DRSC_F_WRSR_RD]) &&
            gap_met(rd_cnt[state.rank],
                    {1'b0, state.spacing[`DRSC_F_RDSR_RD]});
    for (int q = 0; q < NUM_RANKS; q++) begin
      if (2'(q) != state.rank) begin
        rd_ok = rd_ok &&
          gap_met(wr_cnt[q], {2'h0, state.spacing[`DRSC_F_WRDR_RD]}) &&
          gap_met(rd_cnt[q], {1'b0, state.spacing[`DRSC_F_RDDR_RD]});
      end
    end
    // Presence bit of the held rank; single module hides the upper two
    pop_ok = |((state.cke_ctrl[`DRSC_F_PRESENT] >> state.rank) & 4'h1);
    if (state.cke_ctrl[`DRSC_B_SINGLE] && state.rank[1]) begin
      pop_ok = 1'b0;
    end

    // Hold, issue or drop the pending command
    if (state.pend) begin
      if (!pop_ok) begin
        next_state.drop = 1'b1;
        next_state.pend = 1'b0;
      end else if (state.kind == drsc_pkg::DRSC_READ) begin
        if (cke_link.read_ok && rd_ok) begin
          next_state.issue = 1'b1;
          next_state.pend = 1'b0;
        end
      end else if (cke_link.nonread_ok) begin
        next_state.issue = 1'b1;
        next_state.pend = 1'b0;
      end
    end else if (i_cmd_valid && state.ready) begin
      next_state.pend = 1'b1;
      next_state.kind = i_cmd_kind;
      next_state.rank = i_cmd_rank;
      next_state.bank = i_cmd_bank;
    end
    next_state.ready = !next_state.pend;

    // Termination safe: low for the programmed clocks after a start
    for (int t = 0; t < 2; t++) begin
      dly = (t == 0) ? state.cke_ctrl[`DRSC_F_RD_TERM_DLY] :
                       state.cke_ctrl[`DRSC_F_WR_TERM_DLY];
      if (((t == 0) ? i_rd_term_start : i_wr_term_start) &&
          state.cke_ctrl[`DRSC_B_RD_UNSAFE - t]) begin
        next_state.term_cnt[t] = dly;
      end else if (state.term_cnt[t] != 2'h0) begin
        next_state.term_cnt[t] = state.term_cnt[t] - 2'h1;
      end
      next_state.term_safe[t] = !state.cke_ctrl[`DRSC_B_RD_UNSAFE - t] ||
                                next_state.term_cnt[t] == 2'h0;
    end
  end

  // Registers take their documented reset values
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= '{spacing: `DRSC_RST_READ_SPACING,
                 cke_ctrl: `DRSC_RST_CKE_CTRL, rdata: 32'h00000000,
                 rvalid: 1'b0, ready: 1'b1, pend: 1'b0, kind: 2'h0,
                 rank: 2'h0, bank: 3'h0, issue: 1'b0, drop: 1'b0,
                 term_cnt: 4'h0, term_safe: 2'h3};
    end else begin
      state <= next_state;
    end
  end

  // All outputs are flops of the state or of the sequencer
  assign o_reg_rdata = state.rdata;
  assign o_reg_rvalid = state.rvalid;
  assign o_cmd_ready = state.ready;
  assign o_issue_valid = state.issue;
  assign o_issue_kind = state.kind;
  assign o_issue_rank = state.rank;
  assign o_issue_bank = state.bank;
  assign o_cmd_drop = state.drop;
  assign o_cke = cke_link.cke;
  assign o_rd_term_safe = state.term_safe[0];
  assign o_wr_term_safe = state.term_safe[1];

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence read_out_s;
    o_issue_valid && o_issue_kind == drsc_pkg::DRSC_READ;
  endsequence
  sequence rd_term_go_s;
    i_rd_term_start && state.cke_ctrl[`DRSC_B_RD_UNSAFE] &&
      state.cke_ctrl[`DRSC_F_RD_TERM_DLY] == 2'h3;
  endsequence

  act_read_gap_a: assert property (
    read_out_s |-> act_cnt[{o_issue_rank, o_issue_bank}] >=
      {1'b0, state.spacing[`DRSC_F_ACT_RD]})
    else $error("read too soon after activate");
  write_read_gap_a: assert property (
    read_out_s |-> wr_cnt[o_issue_rank] >= state.spacing[`DRSC_F_WRSR_RD])
    else $error("read too soon after same-rank write");
  present_rank_a: assert property (
    o_issue_valid |-> o_cke[o_issue_rank])
    else $error("command sent to a rank without clock enable");
  reserved_zero_a: assert property (
    o_reg_rvalid && $past(i_reg_addr) == `DRSC_OFF_READ_SPACING |->
      o_reg_rdata[31:20] == 12'h000)
    else $error("reserved spacing bits not zero");
  rd_term_delay_a: assert property (
    rd_term_go_s |=> !o_rd_term_safe [*3] ##1 o_rd_term_safe)
    else $error("read termination safe at wrong time");
  wr_term_idle_a: assert property (
    !state.cke_ctrl[`DRSC_B_WR_UNSAFE] ##1
      !state.cke_ctrl[`DRSC_B_WR_UNSAFE] |-> o_wr_term_safe)
    else $error("write termination unsafe while not selected");
  single_module_a: assert property (
    o_issue_valid |-> !($past(state.cke_ctrl[`DRSC_B_SINGLE]) &&
                        o_issue_rank[1]))
    else $error("upper rank used on single-module channel");
  drop_absent_a: assert property (
    state.pend &&
      ((state.cke_ctrl[`DRSC_F_PRESENT] >> state.rank) & 4'h1) == 4'h0 |=>
      o_cmd_drop && !o_issue_valid)
    else $error("command to absent rank not dropped");
endmodule // drsc_read_spacing

// ---- tb/drsc_rank_model.sv ----
`timescale 1ns/1ps
// Memory ranks seen from the pins: any command reaching a sleeping
// rank would be lost, so those are counted
module drsc_rank_model (
  // Clock
  input wire logic i_sys_clk,
  // Command side
  input wire logic [3:0] i_cke,
  input wire logic i_issue_valid,
  input wire logic [1:0] i_issue_rank,
  // Lost commands
  output int o_bad_count
);
  initial o_bad_count = 0;
  // A rank with clock enable low ignores the bus
  always @(posedge i_sys_clk) begin
    if (i_issue_valid && i_cke[i_issue_rank] !== 1'b1) begin
      o_bad_count <= o_bad_count + 1;
    end
  end
endmodule // drsc_rank_model

// ---- tb/test_dram_read_spacing_cke_control.sv ----
`timescale 1ns/1ps
module test_dram_read_spacing_cke_control;
  logic i_sys_clk, i_rstn, reg_wr, reg_rd, rvalid, cmd_valid, cmd_ready;
  logic issue_valid, cmd_drop, pd_req, rd_start, wr_start, rd_safe, wr_safe;
  logic [11:0] reg_addr;
  logic [31:0] wdata, rdata;
  logic [1:0] cmd_kind, cmd_rank;
  logic [2:0] cmd_bank;
  logic [3:0] cke;
  logic [1:0] issue_kind, issue_rank;
  logic [2:0] issue_bank;
  int fail_count = 0, num_checks = 0, cyc = 0, bad;

  drsc_read_spacing i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_be(4'hf), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind),
    .i_cmd_rank(cmd_rank), .i_cmd_bank(cmd_bank), .o_cmd_ready(cmd_ready),
    .o_issue_valid(issue_valid), .o_issue_kind(issue_kind),
    .o_issue_rank(issue_rank), .o_issue_bank(issue_bank),
    .o_cmd_drop(cmd_drop), .i_pd_req(pd_req), .o_cke(cke),
    .i_rd_term_start(rd_start), .i_wr_term_start(wr_start),
    .o_rd_term_safe(rd_safe), .o_wr_term_safe(wr_safe));
  drsc_rank_model i_ranks (.i_sys_clk(i_sys_clk), .i_cke(cke),
    .i_issue_valid(issue_valid), .i_issue_rank(issue_rank),
    .o_bad_count(bad));

  // Clock and cycle count used to measure spacings
  initial begin
    i_sys_clk = 0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge i_sys_clk);
    reg_wr = 1;
    reg_addr = a;
    wdata = d;
    @(negedge i_sys_clk);
    reg_wr = 0;
  endtask

  // Read back and compare; rdata holds, so a late pulse is still caught
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    int n;
    @(negedge i_sys_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge i_sys_clk);
    reg_rd = 0;
    for (n = 0; n < 3 && rvalid !== 1'b1; n++) @(negedge i_sys_clk);
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask

  // One command; returns the cycle of its issue or drop
  task automatic cmd(input logic [1:0] k, r, output int at, output logic d);
    int n;
    @(negedge i_sys_clk);
    cmd_valid = 1;
    cmd_kind = k;
    cmd_rank = r;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    cmd_valid = 0;
    for (n = 0; n < 60 && !(issue_valid || cmd_drop); n++)
      @(negedge i_sys_clk);
    at = cyc;
    d = cmd_drop;
    chk({25'h0, issue_kind, issue_rank, issue_bank}, {25'h0, k, r, cmd_bank});
    chk({31'h0, issue_valid | cmd_drop}, 32'h1);
  endtask

  // First command then a read; the read must trail by exactly the gap
  task automatic gap(input logic [31:0] sp, input logic [1:0] k, r1, r2,
                     input int g);
    int a1, a2;
    logic d;
    wr(12'h658, sp);
    cmd(k, r1, a1, d);
    cmd(2'h1, r2, a2, d);
    chk(a2 - a1, g);
  endtask

  task automatic t_term();
    int n;
    wr(12'h660, 32'hd0f0c800);
    @(negedge i_sys_clk);
    rd_start = 1;
    wr_start = 1;
    @(negedge i_sys_clk);
    rd_start = 0;
    wr_start = 0;
    for (n = 1; n <= 4; n++) begin
      chk({31'h0, rd_safe}, {31'h0, n > 3});
      chk({31'h0, wr_safe}, {31'h0, n > 1});
      @(negedge i_sys_clk);
    end
    $display("termination test done");
  endtask

  task automatic t_regs();
    rd(12'h658, 32'h0);
    rd(12'h660, 32'h800);
    wr(12'h658, 32'hffffffff);
    rd(12'h658, 32'h000fffff);
    rd(12'h664, 32'h0);
    chk(cke, 4'h0);
    $display("register test done");
  endtask

  // Exit wait 4: a read is held for the wait, then two pipeline edges
  task automatic t_srx();
    int n, r0, at;
    logic d;
    wr(12'h660, 32'h08f00808);
    for (n = 0; n < 30 && cke !== 4'hf; n++) @(negedge i_sys_clk);
    chk(cke, 4'hf);
    r0 = cyc;
    cmd(2'h1, 2'h0, at, d);
    chk(at - r0, 4 + 2);
    rd(12'h660, 32'h00f00808);
    $display("self-refresh exit test done");
  endtask

  task automatic t_spacing();
    cmd_bank = 3'h1;
    gap(32'h00090000, 2'h0, 2'h0, 2'h0, 9);
    gap(32'h0000a000, 2'h2, 2'h1, 2'h1, 20);
    gap(32'h00000700, 2'h2, 2'h0, 2'h1, 7);
    gap(32'h00000080, 2'h1, 2'h2, 2'h2, 8);
    gap(32'h0000000b, 2'h1, 2'h3, 2'h0, 11);
    $display("spacing test done");
  endtask

  // Disabled first, then high width 2, low width 3, exit gap code 9
  task automatic t_pdn();
    int n, r0, at;
    logic d;
    pd_req = 1;
    repeat (12) @(negedge i_sys_clk);
    chk(cke, 4'hf);
    pd_req = 0;
    wr(12'h660, 32'h02f72400);
    pd_req = 1;
    for (n = 0; n < 10 && cke !== 4'h0; n++) @(negedge i_sys_clk);
    chk(cke, 4'h0);
    pd_req = 0;
    for (n = 0; n < 10 && cke !== 4'hf; n++) @(negedge i_sys_clk);
    chk(n, 3);
    pd_req = 1;
    for (n = 0; n < 10 && cke !== 4'h0; n++) @(negedge i_sys_clk);
    chk(n, 2);
    pd_req = 0;
    for (n = 0; n < 10 && cke !== 4'hf; n++) @(negedge i_sys_clk);
    chk(n, 3);
    r0 = cyc;
    cmd(2'h0, 2'h0, at, d);
    chk(at - r0, 9);
    $display("power-down test done");
  endtask

  task automatic t_rank();
    int a;
    logic d;
    wr(12'h660, 32'h00f00801);
    cmd(2'h1, 2'h3, a, d);
    chk(d, 1'b1);
    wr(12'h660, 32'h00700800);
    cmd(2'h1, 2'h3, a, d);
    chk(d, 1'b1);
    cmd(2'h1, 2'h0, a, d);
    chk(d, 1'b0);
    chk(bad, 0);
    $display("rank test done");
  endtask

  initial begin
    {reg_wr, reg_rd, cmd_valid, pd_req, rd_start, wr_start} = 0;
    {reg_addr, wdata, cmd_kind, cmd_rank, cmd_bank} = 0;
    i_rstn = 0;
    repeat (5) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rstn = 1;
    t_regs();
    t_srx();
    t_spacing();
    t_pdn();
    t_term();
    t_rank();
    report_and_stop();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule // test_dram_read_spacing_cke_control
